// File: bus_events.v
// edge and start/stop detection on synchronised clock and data lines
module bus_events (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_scl,
  input  wire i_sda,
  output wire o_scl_rise,
  output wire o_scl_fall,
  output wire o_start,
  output wire o_stop
);

  reg scl_prev_reg;
  reg sda_prev_reg;

  // one-cycle history of both lines
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= i_scl;
      sda_prev_reg <= i_sda;
    end
  end

  // data moving while clock stays high marks a frame boundary
  assign o_scl_rise = i_scl & ~scl_prev_reg;
  assign o_scl_fall = ~i_scl & scl_prev_reg;
  assign o_start    = i_scl & scl_prev_reg & sda_prev_reg & ~i_sda;
  assign o_stop     = i_scl & scl_prev_reg & ~sda_prev_reg & i_sda;

endmodule // bus_events

// File: bus_master_model.sv
// bus master model driving the serial clock and the open-drain data line
module bus_master_model (
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: both lines released, clock stands still outside frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // start or repeated start, clock left low
  task automatic start();
    o_sda_low = 1'b0;
    #80 o_scl = 1'b1;
    #80 o_sda_low = 1'b1;
    #80 o_scl = 1'b0;
  endtask
  // data moves only while the clock is low
  task automatic put_bit(input logic b);
    #20 o_sda_low = !b;
    #60 o_scl = 1'b1;
    #80 o_scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #20 o_sda_low = 1'b0;
    #60 o_scl = 1'b1;
    #40 b = i_sda;
    #40 o_scl = 1'b0;
  endtask
  // msb first; ack read back only when the byte is whole
  task automatic wr(input logic [7:0] d, input int n, output logic ack);
    logic b;
    ack = 1'b0;
    for (int i = 0; i < n; i++) put_bit(d[7-i]);
    if (n == 8) begin
      get_bit(b);
      ack = !b;
    end
  endtask
  // master acks each byte but the last
  task automatic rd(output logic [7:0] d, input logic more);
    for (int i = 0; i < 8; i++) get_bit(d[7-i]);
    put_bit(!more);
  endtask
  // datagram closed by a stop: data rises while the clock is high
  task automatic stop();
    #20 o_sda_low = 1'b1;
    #60 o_scl = 1'b1;
    #80 o_sda_low = 1'b0;
    #160;
  endtask
endmodule // bus_master_model

// File: line_sync.v
// two-stage synchroniser for asynchronous input lines
module line_sync #(
  parameter WIDTH = 2
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  // idle bus rests high, so both stages reset to one
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule // line_sync

// File: tb.sv
// self-checking bench for the two-wire serial slave port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk;
  logic        i_rst;
  logic        pin;
  logic [3:0]  prog;
  logic [7:0]  tx_data;
  logic [7:0]  data [0:8];
  logic [10:0] rxq [$];
  logic [31:0] seed;
  int          errors;
  int          comparisons;
  int          ends;
  wire         scl;
  wire         m_low;
  wire         sda_out;
  wire         sda_oe_n;
  wire         sda;
  wire [7:0]   rx_data;
  wire         rx_valid;
  wire [2:0]   rx_index;
  wire         rx_gc;
  wire [7:0]   reg_addr;
  wire [2:0]   tx_index;
  wire         frame_end;
  // pulled-up line, low while either party drives it
  assign sda = !(m_low || (!sda_oe_n && !sda_out));
  bus_master_model m_u (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
  two_wire_slave dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_address_select_pin(pin),
    .i_prog_addr_bit3(prog[3]), .i_prog_addr_bit2(prog[2]),
    .i_prog_addr_bit1(prog[1]), .i_prog_addr_bit0(prog[0]),
    .i_tx_data(tx_data), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_rx_index(rx_index), .o_rx_general_call(rx_gc), .o_reg_addr(reg_addr),
    .o_read_full_status_cmd(), .o_tx_load(), .o_tx_index(tx_index),
    .o_read_active(), .o_bus_start(), .o_frame_end(frame_end)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = !i_clk;
  end
  // capture received bytes; read data follows the register address
  always @(posedge i_clk) begin
    if (rx_valid === 1'b1) rxq.push_back({rx_index, rx_data});
    if (frame_end === 1'b1) ends++;
    tx_data <= reg_addr + {5'h00, tx_index};
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [6:0] own_addr(input logic p, input logic [3:0] g);
    return {2'b11, g, p};
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one write datagram; hit says whether the device should answer
  task automatic write_frame(input logic [7:0] a, input int n, input logic hit);
    logic ack;
    int want;
    rxq.delete();
    ends = 0;
    m_u.start();
    m_u.wr(a, 8, ack);
    check1(ack, hit);
    for (int k = 0; k < n; k++) begin
      m_u.wr(data[k], 8, ack);
      check1(ack, hit && k < 8);
    end
    m_u.stop();
    want = hit ? ((n > 8) ? 8 : n) : 0;
    check8(8'(rxq.size()), 8'(want));
    // an addressed frame closed by a stop reports its end exactly once
    check1(ends == 1, hit);
    for (int k = 0; k < want; k++) begin
      check8(rxq[k][7:0], data[k]);
      check8({5'h00, rxq[k][10:8]}, 8'(k));
    end
    if (hit) check8(reg_addr, data[0]);
  endtask
  // register address write, then read datagram of n bytes
  task automatic read_frame(input logic [6:0] a, input int n);
    logic ack;
    logic [7:0] d;
    data[0] = rnd();
    write_frame({a, 1'b0}, 1, 1'b1);
    m_u.start();
    m_u.wr({a, 1'b1}, 8, ack);
    check1(ack, 1'b1);
    for (int k = 0; k < n; k++) begin
      m_u.rd(d, k < n - 1);
      check8(d, data[0] + 8'(k));
    end
    m_u.stop();
  endtask
  // guard against a hang, set well beyond the length of the whole run
  initial begin
    #900000;
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end
  initial begin
    logic ack;
    logic [7:0] v;
    logic [7:0] w;
    logic [6:0] a7;
    logic h;
    int n;
    seed = 32'h0000_001f;
    errors = 0;
    comparisons = 0;
    ends = 0;
    i_rst = 1'b1;
    pin = 1'b0;
    prog = 4'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    // frames start on the falling edge, so the lines never race the sampling edge
    repeat (3) @(negedge i_clk);
    // unprogrammed address, pin low: status command plus a ninth byte
    for (int k = 0; k < 9; k++) data[k] = rnd();
    data[0] = 8'h81;
    write_frame(8'hc0, 9, 1'b1);
    read_frame(7'h60, 2);
    @(posedge i_clk);
    pin <= 1'b1;
    @(negedge i_clk);
    write_frame(8'hc2, 2, 1'b1);
    write_frame(8'hc0, 2, 1'b0);
    write_frame(8'h00, 2, 1'b1);
    check1(rx_gc, 1'b1);
    // general call is refused for reads
    m_u.start();
    m_u.wr(8'h01, 8, ack);
    check1(ack, 1'b0);
    m_u.stop();
    // partial byte abandoned by a repeated start
    m_u.start();
    m_u.wr(8'hc3, 5, ack);
    data[0] = rnd();
    write_frame(8'hc2, 1, 1'b1);
    // random select pin, programmed bits, addresses and counts
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      w = rnd();
      @(posedge i_clk);
      pin <= v[0];
      prog <= v[4:1];
      @(negedge i_clk);
      a7 = v[5] ? own_addr(v[0], v[4:1]) : w[6:0];
      h = a7 == own_addr(v[0], v[4:1]) || a7 == 7'h00;
      n = 1 + int'(w[7:5]);
      for (int k = 0; k < n; k++) data[k] = rnd();
      if (v[5] && v[7]) read_frame(a7, n);
      else write_frame({a7, 1'b0}, n, h);
    end
    test_done();
  end
endmodule // tb
bind two_wire_slave two_wire_slave_checker chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda_in(i_sda_in),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_rx_data(o_rx_data),
  .o_rx_valid(o_rx_valid), .o_rx_index(o_rx_index), .o_rx_general_call(o_rx_general_call),
  .o_read_full_status_cmd(o_read_full_status_cmd), .o_tx_load(o_tx_load),
  .o_read_active(o_read_active), .o_bus_start(o_bus_start), .o_frame_end(o_frame_end)
);

// File: two_wire_consts.vh
// constants shared by the two-wire serial slave port
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH
// address field layout: two fixed high bits, four programmable, one pin
`define TW_ADDR_FIXED_HI  2'h3
`define TW_GENERAL_CALL   7'h00
// bit index of the direction flag in the address byte (1 = read)
`define TW_DIR_BIT        0
// index of the last bit inside a byte (8 bits, msb first)
`define TW_LAST_BIT       3'h7
// most data bytes accepted in one write datagram
`define TW_MAX_BYTES      4'h8
// command code of the full status read
`define TW_FULL_STATUS_CMD 8'h81
// reset values
`define TW_RST_BYTE       8'h00
`define TW_RST_CNT3       3'h0
`define TW_RST_CNT4       4'h0
`endif

// File: two_wire_slave.v
// two-wire serial bus slave port: address match, write receive, read send
//
// Notes on behaviour
// - start: data falls while clock high
// - stop: data rises while clock high
// - idle bus leaves both lines released high
// - data changes only while clock low
// - sample data on every clock rising edge
// - bytes are eight bits, msb first
// - receiver acknowledges every byte; this port leaves a ninth data byte unacknowledged
// - address: two ones, four programmable, pin
// - also answer general call address zero; this port answers it for writes only
// - unprogrammed: C0/C1 pin low, C2/C3 high
// - address lsb one reads, zero writes
// - write: start, address, acks, data, stop
// - device pulls data low to acknowledge
// - command writes carry eight or two bytes
// - keep received register address for read
// - read: address with read bit, shift out
// - first data byte is command; 0x81 status
`include "two_wire_consts.vh"

module two_wire_slave (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_scl,
  input  wire       i_sda_in,
  output wire       o_sda_out,
  output wire       o_sda_oe_n,
  input  wire       i_address_select_pin,
  input  wire       i_prog_addr_bit3,
  input  wire       i_prog_addr_bit2,
  input  wire       i_prog_addr_bit1,
  input  wire       i_prog_addr_bit0,
  input  wire [7:0] i_tx_data,
  output wire [7:0] o_rx_data,
  output wire       o_rx_valid,
  output wire [2:0] o_rx_index,
  output wire       o_rx_general_call,
  output wire [7:0] o_reg_addr,
  output wire       o_read_full_status_cmd,
  output wire       o_tx_load,
  output wire [2:0] o_tx_index,
  output wire       o_read_active,
  output wire       o_bus_start,
  output wire       o_frame_end
);

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_ADDR     = 3'h1;
  localparam [2:0] ST_ADDR_END = 3'h2;
  localparam [2:0] ST_ACK      = 3'h3;
  localparam [2:0] ST_RX       = 3'h4;
  localparam [2:0] ST_RX_END   = 3'h5;
  localparam [2:0] ST_TX       = 3'h6;
  localparam [2:0] ST_TX_ACK   = 3'h7;

  wire [2:0] line_sync_out;
  wire       scl_s;
  wire       sda_s;
  wire       pin_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire [6:0] own_addr;
  wire [7:0] rx_byte;

  reg  [2:0] state_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] tx_shift_reg;
  reg  [3:0] byte_cnt_reg;
  reg        dir_read_reg;
  reg        addressed_reg;
  reg        tx_more_reg;
  reg        rx_ok_reg;
  reg        sda_out_reg;
  reg        sda_oe_n_reg;
  reg  [7:0] rx_data_reg;
  reg        rx_valid_reg;
  reg  [2:0] rx_index_reg;
  reg        general_call_reg;
  reg  [7:0] reg_addr_reg;
  reg        full_status_reg;
  reg        tx_load_reg;
  reg  [2:0] tx_index_reg;
  reg        bus_start_reg;
  reg        frame_end_reg;
  reg        read_active_reg;

  // clock, data and the select pin are asynchronous: two flops first
  line_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_scl, i_sda_in, i_address_select_pin}),
    .o_sync  (line_sync_out)
  );

  assign scl_s = line_sync_out[2];
  assign sda_s = line_sync_out[1];
  assign pin_s = line_sync_out[0];

  bus_events u_events (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_scl      (scl_s),
    .i_sda      (sda_s),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (bus_start),
    .o_stop     (bus_stop)
  );

  // physical address: fixed ones, programmable bits, select pin in lsb
  assign own_addr = {`TW_ADDR_FIXED_HI, i_prog_addr_bit3, i_prog_addr_bit2,
                     i_prog_addr_bit1, i_prog_addr_bit0,
                     pin_s};

  // byte completed by the bit being sampled on this rising edge
  assign rx_byte = {shift_reg[6:0], sda_s};

  // general call is write-only; a read to address zero is not answered
  function addr_hit;
    input [7:0] field;
    input [6:0] own;
    begin
      addr_hit = (field[7:1] == own) ||
                 ((field[7:1] == `TW_GENERAL_CALL) &&
                  !field[`TW_DIR_BIT]);
    end
  endfunction

  // protocol engine; every bit step waits for a detected clock edge
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg        <= ST_IDLE;
      bit_cnt_reg      <= `TW_RST_CNT3;
      shift_reg        <= `TW_RST_BYTE;
      tx_shift_reg     <= `TW_RST_BYTE;
      byte_cnt_reg     <= `TW_RST_CNT4;
      dir_read_reg     <= 1'b0;
      addressed_reg    <= 1'b0;
      tx_more_reg      <= 1'b0;
      rx_ok_reg        <= 1'b0;
      sda_out_reg      <= 1'b0;
      sda_oe_n_reg     <= 1'b1;
      rx_data_reg      <= `TW_RST_BYTE;
      rx_valid_reg     <= 1'b0;
      rx_index_reg     <= `TW_RST_CNT3;
      general_call_reg <= 1'b0;
      reg_addr_reg     <= `TW_RST_BYTE;
      full_status_reg  <= 1'b0;
      tx_load_reg      <= 1'b0;
      tx_index_reg     <= `TW_RST_CNT3;
      bus_start_reg    <= 1'b0;
      frame_end_reg    <= 1'b0;
      read_active_reg  <= 1'b0;
    end else begin
      // pulses last one cycle
      rx_valid_reg    <= 1'b0;
      full_status_reg <= 1'b0;
      tx_load_reg     <= 1'b0;
      bus_start_reg   <= 1'b0;
      frame_end_reg   <= 1'b0;
      if (bus_start) begin
        // a start in mid-byte simply begins a new address phase
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= `TW_RST_CNT3;
        byte_cnt_reg  <= `TW_RST_CNT4;
        sda_oe_n_reg  <= 1'b1;
        addressed_reg <= 1'b0;
        read_active_reg <= 1'b0;
        bus_start_reg <= 1'b1;
      end else if (bus_stop) begin
        state_reg     <= ST_IDLE;
        sda_oe_n_reg  <= 1'b1;
        addressed_reg <= 1'b0;
        read_active_reg <= 1'b0;
        frame_end_reg <= addressed_reg;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == `TW_LAST_BIT) begin
                state_reg <= ST_ADDR_END;
              end
            end
          end
          ST_ADDR_END: begin
            // acknowledge only once the clock is low again
            if (scl_fall) begin
              if (addr_hit(shift_reg, own_addr)) begin
                sda_oe_n_reg     <= 1'b0;
                dir_read_reg     <= shift_reg[`TW_DIR_BIT];
                read_active_reg  <= shift_reg[`TW_DIR_BIT];
                addressed_reg    <= 1'b1;
                general_call_reg <= (shift_reg[7:1] == `TW_GENERAL_CALL);
                tx_more_reg      <= 1'b0;
                tx_index_reg     <= `TW_RST_CNT3;
                state_reg        <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // end of an ack slot: either hand over to data or load a byte
            if (scl_fall) begin
              bit_cnt_reg <= `TW_RST_CNT3;
              if (dir_read_reg) begin
                tx_shift_reg <= {i_tx_data[6:0], 1'b0};
                sda_oe_n_reg <= i_tx_data[7];
                tx_load_reg  <= 1'b1;
                tx_index_reg <= tx_index_reg + 3'h1;
                state_reg    <= ST_TX;
              end else begin
                sda_oe_n_reg <= 1'b1;
                state_reg    <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == `TW_LAST_BIT) begin
                state_reg <= ST_RX_END;
                rx_ok_reg <= (byte_cnt_reg < `TW_MAX_BYTES);
                if (byte_cnt_reg < `TW_MAX_BYTES) begin
                  rx_data_reg  <= rx_byte;
                  rx_index_reg <= byte_cnt_reg[2:0];
                  rx_valid_reg <= 1'b1;
                end
                if (byte_cnt_reg == `TW_RST_CNT4) begin
                  // first data byte: command code or register address
                  reg_addr_reg    <= rx_byte;
                  full_status_reg <= (rx_byte == `TW_FULL_STATUS_CMD);
                end
              end
            end
          end
          ST_RX_END: begin
            // a ninth byte gets no ack and is dropped
            if (scl_fall) begin
              if (rx_ok_reg) begin
                sda_oe_n_reg <= 1'b0;
                byte_cnt_reg <= byte_cnt_reg + 4'h1;
                state_reg    <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_TX: begin
            // next bit goes out on each falling edge, released after the lsb
            if (scl_fall) begin
              if (bit_cnt_reg == `TW_LAST_BIT) begin
                sda_oe_n_reg <= 1'b1;
                state_reg    <= ST_TX_ACK;
              end else begin
                sda_oe_n_reg <= tx_shift_reg[7];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                bit_cnt_reg  <= bit_cnt_reg + 3'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              tx_more_reg <= ~sda_s;
              if (sda_s) begin
                state_reg <= ST_IDLE;
              end
            end else if (scl_fall && tx_more_reg) begin
              tx_shift_reg <= {i_tx_data[6:0], 1'b0};
              sda_oe_n_reg <= i_tx_data[7];
              tx_load_reg  <= 1'b1;
              tx_index_reg <= tx_index_reg + 3'h1;
              bit_cnt_reg  <= `TW_RST_CNT3;
              tx_more_reg  <= 1'b0;
              state_reg    <= ST_TX;
            end
          end
          default: begin
            // idle: line released, waiting for a start
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // open-drain: the pin is only ever pulled low, never driven high;
  // the clock line is an input only, the master owns it
  assign o_sda_out              = sda_out_reg;
  assign o_sda_oe_n             = sda_oe_n_reg;
  assign o_rx_data              = rx_data_reg;
  assign o_rx_valid             = rx_valid_reg;
  assign o_rx_index             = rx_index_reg;
  assign o_rx_general_call      = general_call_reg;
  assign o_reg_addr             = reg_addr_reg;
  assign o_read_full_status_cmd = full_status_reg;
  assign o_tx_load              = tx_load_reg;
  assign o_tx_index             = tx_index_reg;
  assign o_read_active          = read_active_reg;
  assign o_bus_start            = bus_start_reg;
  assign o_frame_end            = frame_end_reg;

endmodule // two_wire_slave

// File: two_wire_slave_assertions.sv
// assertion checker watching the two-wire slave port pins
module two_wire_slave_checker (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_sda_in,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe_n,
  input wire logic [7:0] o_rx_data,
  input wire logic       o_rx_valid,
  input wire logic [2:0] o_rx_index,
  input wire logic       o_rx_general_call,
  input wire logic       o_read_full_status_cmd,
  input wire logic       o_tx_load,
  input wire logic       o_read_active,
  input wire logic       o_bus_start,
  input wire logic       o_frame_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // open drain: only the enable may move the line
  a_sda_value_low: assert property (
    o_sda_out == 1'b0) else $error("data value not low");
  // enable moves only while the clock is low, never in a high phase
  a_oe_change_low: assert property (
    $changed(o_sda_oe_n) |-> !i_scl) else $error("enable moved with clock high");
  a_oe_stable_high: assert property (
    i_scl [*6] |-> $stable(o_sda_oe_n)) else $error("enable moved in high phase");
  // start on the pins is reported within a few clocks
  a_start_seen: assert property (
    $fell(i_sda_in) && i_scl && $past(i_scl) |-> ##[1:5] o_bus_start)
    else $error("start not reported");
  a_frame_end_idle: assert property (
    o_frame_end |-> i_scl && i_sda_in) else $error("frame end without stop");
  a_rx_one_pulse: assert property (
    o_rx_valid |=> !o_rx_valid) else $error("receive pulse too long");
  a_status_cmd: assert property (
    o_read_full_status_cmd |-> o_rx_valid && o_rx_index == 3'h0 && o_rx_data == 8'h81)
    else $error("status command flag wrong");
  a_rx_write_only: assert property (
    o_rx_valid |-> !o_read_active) else $error("byte received in read");
  a_load_read_only: assert property (
    o_tx_load |-> o_read_active && !o_rx_general_call) else $error("load outside read");
  // main scenarios reached
  c_status: cover property (o_read_full_status_cmd);
  c_load: cover property (o_tx_load);
  c_frame_end: cover property (o_frame_end);
  c_general: cover property (o_rx_valid && o_rx_general_call);
endmodule // two_wire_slave_checker
